// ===== cyclic_io_pkg.sv
// constants shared by the cyclic exchange buffer manager and its application end
//
// Behaviour
// - received outputs fill D, then move to N
// - output advance read moves N to U if new
// - newer output buffer replaces waiting N buffer
// - reset, drop, clear, await-params zero D to N
// - advance read bit 3 flags zeroed buffer
// - output hold keeps D until sync/unsync
// - output state cell reports F,U,N,D fields
// - advance read: U index, bit 2 new
// - application zeroes U output buffer at init
// - application zeroes enlarged bytes in N itself
// - inputs sent from D, N moved first if new
// - submit read moves U to N, returns U
// - input hold: no exchange before send
// - input state cell reports F,U,N,D fields
// - exchange state after acks; app submits first input
// - 16-bit alive counter reloaded, decremented per telegram
// - counter zero: await parameters, drop master
// - rearm bit reloads counter, then clears itself
// - application sets rearm cyclically and at power-up
// - global clear zeroes D, moves to N
// - freeze moves N to D and holds
package cyclic_io_pkg;
  localparam logic [7:0] ADDR_IN_POS = 8'h08;
  localparam logic [7:0] ADDR_IN_SUBMIT = 8'h09;
  localparam logic [7:0] ADDR_OUT_POS = 8'h0A;
  localparam logic [7:0] ADDR_OUT_ADVANCE = 8'h0B;
  localparam int BIT_NEW_U = 2;
  localparam int BIT_CLEARED = 3;
  localparam logic [1:0] BUF_NIL = 2'h0;
  localparam logic [15:0] ALIVE_RESET = 16'h0000;
  localparam logic [7:0] CELL_RESET = 8'h00;
  // APB registers of the application end
  localparam logic [11:0] APB_CTRL = 12'h000;
  localparam logic [11:0] APB_STATUS = 12'h004;
  localparam logic [11:0] APB_RESULT = 12'h008;
  localparam int CTRL_ADVANCE = 0;
  localparam int CTRL_SUBMIT = 1;
  localparam int CTRL_REARM = 2;
  localparam int CTRL_READ_OUT_POS = 3;
  localparam int CTRL_READ_IN_POS = 4;
  localparam int CTRL_ALIVE_LOAD = 5;
  localparam int CTRL_ALIVE_SHIFT = 16;
endpackage

// ===== cyclic_io_if.sv
// link between buffer manager and its application processor end
`timescale 1ns/1ns
interface cyclic_io_if;
  logic rd_req;
  logic [7:0] rd_addr;
  logic rd_ack;
  logic [7:0] rd_data;
  logic rearm_set;
  logic [15:0] alive_reload;
  modport device (input rd_req, input rd_addr, output rd_ack, output rd_data,
    input rearm_set, input alive_reload);
  modport app (output rd_req, output rd_addr, input rd_ack, input rd_data,
    output rearm_set, output alive_reload);
endinterface

// ===== triple_rotor.sv
// three-buffer position tracker, F/U/N/D slots with atomic moves
`timescale 1ns/1ns
module triple_rotor
  import cyclic_io_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic d_to_n,
  input wire logic n_to_d,
  input wire logic n_to_u,
  input wire logic u_to_n,
  input wire logic d_to_n_cleared,
  output logic [1:0] pos_f,
  output logic [1:0] pos_u,
  output logic [1:0] pos_n,
  output logic [1:0] pos_d,
  output logic n_cleared
);
  // one index register per position; a move passes indices among two or three slots, never duplicates
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pos_f <= 2'h3;
      pos_u <= 2'h1;
      pos_n <= BUF_NIL;
      pos_d <= 2'h2;
      n_cleared <= 1'b0;
      // third buffer starts free
    end else if (d_to_n) begin
      // newer buffer replaces older waiting one, old becomes the new D
      pos_n <= pos_d;
      pos_d <= (pos_n != BUF_NIL) ? pos_n : pos_f;
      if (pos_n == BUF_NIL) begin
        pos_f <= BUF_NIL;
      end
      n_cleared <= d_to_n_cleared;
    end else if (n_to_d && pos_n != BUF_NIL) begin
      pos_f <= pos_d;
      pos_d <= pos_n;
      pos_n <= BUF_NIL;
    end else if (n_to_u && pos_n != BUF_NIL) begin
      pos_f <= pos_u;
      pos_u <= pos_n;
      pos_n <= BUF_NIL;
    end else if (u_to_n) begin
      // stale waiting buffer becomes the new U
      pos_n <= pos_u;
      pos_u <= (pos_n != BUF_NIL) ? pos_n : pos_f;
      if (pos_n == BUF_NIL) begin
        pos_f <= BUF_NIL;
      end
    end
  end
  // the index codes 1 to 3 only work if nil is the all-zero code
  if (BUF_NIL != 2'h0) begin : g_bad_nil
    $error("nil code must be zero");
  end
endmodule // triple_rotor

// ===== cyclic_io_device.sv
// buffer manager: output/input triple buffers, hold modes and alive counter
`timescale 1ns/1ns
module cyclic_io_device
  import cyclic_io_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  cyclic_io_if.device link,
  input wire logic out_telegram_ok,
  input wire logic in_send_request,
  input wire logic exchange_telegram,
  input wire logic sync_cmd,
  input wire logic unsync_cmd,
  input wire logic freeze_cmd,
  input wire logic clear_cmd,
  input wire logic master_lost,
  input wire logic enter_await_params,
  input wire logic params_acked,
  input wire logic out_hold_enable,
  input wire logic in_hold_enable,
  output logic output_received_event,
  output logic zero_d_buffer,
  output logic [1:0] out_d_index,
  output logic [1:0] in_d_index,
  output logic cyclic_exchange_state,
  output logic drop_master,
  output logic [15:0] app_alive_counter
);
  // output rotor slots
  logic [1:0] of;
  logic [1:0] ou;
  logic [1:0] on;
  logic [1:0] od;
  // input rotor slots
  logic [1:0] inf;
  logic [1:0] inu;
  logic [1:0] inn;
  logic [1:0] ind;
  logic on_cleared;
  logic out_held;
  logic in_frozen;
  logic app_alive_rearm;
  logic u_cleared;
  logic started;
  logic [7:0] next_rd_data;

  // flag bits must sit above the 2-bit index field and inside the byte
  if (BIT_NEW_U < 2 || BIT_CLEARED < 2 || BIT_NEW_U > 7 || BIT_CLEARED > 7
      || BIT_NEW_U == BIT_CLEARED) begin : g_bad_bits
    $error("status bits overlap the buffer index field");
  end

  wire exchange_seen = cyclic_exchange_state && exchange_telegram;
  wire alive_hit_one = app_alive_counter == 16'h0001;
  // expiry only on the decrement that reaches zero; a pending rearm reloads instead
  wire alive_expired = exchange_seen && !app_alive_rearm && alive_hit_one;
  // power-on push lasts exactly the first edge after reset release
  wire power_on = !started;
  wire zero_event = power_on || master_lost || clear_cmd || enter_await_params
    || alive_expired;
  wire rd_adv = link.rd_req && link.rd_addr == ADDR_OUT_ADVANCE;
  wire rd_sub = link.rd_req && link.rd_addr == ADDR_IN_SUBMIT;
  wire out_fresh = out_telegram_ok && !out_hold_enable;
  wire out_hold_fill = out_telegram_ok && out_hold_enable;
  wire out_release = out_held && (sync_cmd || unsync_cmd);
  // zeroed D pushed to N on any drop or clear
  wire out_push = zero_event || out_fresh || out_release;
  // a push in the same cycle wins, so the read reports no move
  wire out_adv_ok = rd_adv && !out_push && on != BUF_NIL;
  // hold mode blocks the exchange before sending
  wire in_send_take = in_send_request && !in_hold_enable && !in_frozen;
  // freeze takes N once, then holds
  wire in_take = in_send_take || freeze_cmd;
  wire in_submit = rd_sub && !in_take;
  // new U after a submit: the stale waiting buffer if any, else the free one
  wire [1:0] next_in_u = (inn != BUF_NIL) ? inn : inf;

  triple_rotor out_rot (
    .core_clk(core_clk),
    .nrst(nrst),
    .d_to_n(out_push),
    .n_to_d(1'b0),
    .n_to_u(out_adv_ok),
    .u_to_n(1'b0),
    .d_to_n_cleared(zero_event),
    .pos_f(of),
    .pos_u(ou),
    .pos_n(on),
    .pos_d(od),
    .n_cleared(on_cleared)
  );
  // input side never zeroes, so its cleared mark is left open
  triple_rotor in_rot (
    .core_clk(core_clk),
    .nrst(nrst),
    .d_to_n(1'b0),
    .n_to_d(in_take),
    .n_to_u(1'b0),
    .u_to_n(in_submit),
    .d_to_n_cleared(1'b0),
    .pos_f(inf),
    .pos_u(inu),
    .pos_n(inn),
    .pos_d(ind),
    .n_cleared()
  );

  // command-cell answers reflect U after the move of the same cycle; state cells show positions before it
  always_comb begin
    next_rd_data = CELL_RESET;
    unique case (link.rd_addr)
      ADDR_IN_POS: next_rd_data = {inf, inu, inn, ind};
      ADDR_OUT_POS: next_rd_data = {of, ou, on, od};
      ADDR_IN_SUBMIT: next_rd_data = {6'h00, in_submit ? next_in_u : inu};
      ADDR_OUT_ADVANCE: begin
        next_rd_data[1:0] = out_adv_ok ? on : ou;
        next_rd_data[BIT_NEW_U] = out_adv_ok;
        next_rd_data[BIT_CLEARED] = out_adv_ok ? on_cleared : u_cleared;
      end
      default: next_rd_data = CELL_RESET;
    endcase
  end

  // answer one cycle after each request cycle; move and answer share an edge
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      link.rd_ack <= 1'b0;
      link.rd_data <= CELL_RESET;
    end else begin
      link.rd_ack <= link.rd_req;
      link.rd_data <= next_rd_data;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      started <= 1'b0;
    end else begin
      started <= 1'b1;
    end
  end

  // zeroed mark follows the buffer into U and stays until the next move
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      u_cleared <= 1'b0;
    end else if (out_adv_ok) begin
      u_cleared <= on_cleared;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      output_received_event <= 1'b0;
      zero_d_buffer <= 1'b0;
      drop_master <= 1'b0;
    end else begin
      output_received_event <= out_telegram_ok;
      zero_d_buffer <= zero_event;
      drop_master <= alive_expired;
    end
  end

  // a telegram in hold wins over a release in the same cycle
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      out_held <= 1'b0;
    end else if (out_hold_fill) begin
      out_held <= 1'b1;
    end else if (sync_cmd || unsync_cmd) begin
      out_held <= 1'b0;
    end
  end

  // frozen until hold mode is left; a new freeze re-takes N
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      in_frozen <= 1'b0;
    end else if (freeze_cmd) begin
      in_frozen <= 1'b1;
    end else if (!in_hold_enable) begin
      in_frozen <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cyclic_exchange_state <= 1'b0;
    end else if (zero_event) begin
      cyclic_exchange_state <= 1'b0;
    end else if (params_acked) begin
      cyclic_exchange_state <= 1'b1;
    end
  end

  // counter parks at zero; only a rearm brings it back
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      app_alive_counter <= ALIVE_RESET;
    end else if (exchange_seen) begin
      if (app_alive_rearm) begin
        app_alive_counter <= link.alive_reload;
      end else if (app_alive_counter != 16'h0000) begin
        app_alive_counter <= app_alive_counter - 16'h0001;
      end
    end
  end

  // set from the application wins over hardware clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      app_alive_rearm <= 1'b0;
    end else if (link.rearm_set) begin
      app_alive_rearm <= 1'b1;
    end else if (exchange_seen) begin
      app_alive_rearm <= 1'b0;
    end
  end

  assign out_d_index = od;
  assign in_d_index = ind;
endmodule // cyclic_io_device

// ===== cyclic_io_app.sv
// application end: APB slave that issues command-cell reads and rearms
`timescale 1ns/1ns
module cyclic_io_app
  import cyclic_io_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  cyclic_io_if.app link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  typedef enum logic [1:0] {IDLE, WAIT_ACK} st_e;
  st_e st;
  logic [7:0] result;
  logic [15:0] reload;
  logic busy;
  logic [7:0] addr_q;
  logic rearm_q;
  wire wr = psel && penable && pwrite && pready;
  wire wr_ctrl = wr && paddr == APB_CTRL;
  wire [7:0] cmd_addr = pwdata[CTRL_ADVANCE] ? ADDR_OUT_ADVANCE
    : pwdata[CTRL_SUBMIT] ? ADDR_IN_SUBMIT
    : pwdata[CTRL_READ_OUT_POS] ? ADDR_OUT_POS : ADDR_IN_POS;
  wire cmd_go = wr_ctrl && !busy && (pwdata[CTRL_ADVANCE] || pwdata[CTRL_SUBMIT]
    || pwdata[CTRL_READ_OUT_POS] || pwdata[CTRL_READ_IN_POS]);
  wire mapped = paddr == APB_CTRL || paddr == APB_STATUS || paddr == APB_RESULT;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign busy = st == WAIT_ACK;
  assign link.rd_req = busy && !link.rd_ack;
  assign link.rd_addr = addr_q;
  assign link.alive_reload = reload;
  // software must rearm at power-up and cyclically
  assign link.rearm_set = rearm_q;
  always_comb begin
    unique case (paddr)
      APB_CTRL: prdata = {reload, 16'h0000};
      APB_STATUS: prdata = {31'h00000000, busy};
      APB_RESULT: prdata = {24'h000000, result};
      default: prdata = 32'h00000000;
    endcase
  end
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st <= IDLE;
      result <= CELL_RESET;
      reload <= ALIVE_RESET;
      addr_q <= ADDR_IN_POS;
      rearm_q <= 1'b0;
    end else begin
      rearm_q <= wr_ctrl && pwdata[CTRL_REARM];
      if (wr_ctrl && pwdata[CTRL_ALIVE_LOAD]) reload <= pwdata[CTRL_ALIVE_SHIFT +: 16];
      unique case (st)
        IDLE: if (cmd_go) begin
          addr_q <= cmd_addr;
          st <= WAIT_ACK;
        end
        WAIT_ACK: if (link.rd_ack) begin
          result <= link.rd_data;
          st <= IDLE;
        end
        default: st <= IDLE;
      endcase
    end
  end
endmodule // cyclic_io_app

// ===== cyclic_io_assertions.sv
// link checker for the buffer manager command cells
`timescale 1ns/1ns
module cyclic_io_assertions
  import cyclic_io_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic rd_req,
  input wire logic [7:0] rd_addr,
  input wire logic rd_ack,
  input wire logic [7:0] rd_data,
  input wire logic rearm_set,
  input wire logic [15:0] alive_reload
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [7:0] req_addr;
  logic [1:0] out_u;
  logic [1:0] in_u;
  // only command reads move U, so the last answer predicts the state cell
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      req_addr <= 8'h00;
      out_u <= 2'h1;
      in_u <= 2'h1;
    end else begin
      req_addr <= rd_addr;
      if (rd_ack && req_addr == ADDR_OUT_ADVANCE) out_u <= rd_data[1:0];
      if (rd_ack && req_addr == ADDR_IN_SUBMIT) in_u <= rd_data[1:0];
    end
  end
  function automatic logic distinct(logic [7:0] v);
    distinct = 1'b1;
    for (int i = 0; i < 4; i++)
      for (int j = i + 1; j < 4; j++)
        if (v[2*i+:2] != BUF_NIL && v[2*i+:2] == v[2*j+:2]) distinct = 1'b0;
  endfunction
  sequence s_read(logic [7:0] a);
    rd_req && rd_addr == a ##1 rd_ack;
  endsequence
  chk_ack_follows_req: assert property (
    rd_req && !rd_ack |=> rd_ack) else $error("no answer one cycle after read request");
  chk_ack_has_req: assert property (
    rd_ack |-> $past(rd_req)) else $error("answer without a request");
  chk_ack_one_cycle: assert property (
    rd_ack |=> !rd_ack) else $error("answer longer than one cycle");
  chk_advance_fields: assert property (
    s_read(ADDR_OUT_ADVANCE) |-> rd_data[7:4] == 4'h0 && rd_data[1:0] != BUF_NIL)
    else $error("bad advance answer");
  chk_submit_fields: assert property (
    s_read(ADDR_IN_SUBMIT) |-> rd_data[7:2] == 6'h00 && rd_data[1:0] != BUF_NIL)
    else $error("bad submit answer");
  chk_out_pos_unique: assert property (
    s_read(ADDR_OUT_POS) |-> distinct(rd_data)) else $error("output buffer in two places");
  chk_in_pos_unique: assert property (
    s_read(ADDR_IN_POS) |-> distinct(rd_data)) else $error("input buffer in two places");
  chk_out_u_tracks: assert property (
    s_read(ADDR_OUT_POS) |-> rd_data[5:4] == out_u) else $error("output U moved unasked");
  chk_in_u_tracks: assert property (
    s_read(ADDR_IN_POS) |-> rd_data[5:4] == in_u) else $error("input U moved unasked");
  chk_advance_moves_u: assert property (
    s_read(ADDR_OUT_ADVANCE) |-> rd_data[2] == (rd_data[1:0] != out_u))
    else $error("advance flag disagrees with U change");
  chk_rearm_one_cycle: assert property (
    rearm_set |=> !rearm_set) else $error("rearm held longer than one cycle");
endmodule // cyclic_io_assertions

// ===== cyclic_io_triple_buffer_wdog_tb.sv
// bench joining buffer manager and application end, driven over APB
`timescale 1ns/1ns
module cyclic_io_triple_buffer_wdog_tb
  import cyclic_io_pkg::*;
();
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic [9:0] ev = '0;
  logic out_hold = 1'b0;
  logic in_hold = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic output_received_event;
  logic [1:0] in_d_index;
  logic [1:0] out_d_index;
  logic zero_d_buffer;
  logic drop_master;
  int n_zeroes = 0;
  int n_drops = 0;
  logic cyclic_exchange_state;
  logic [15:0] app_alive_counter;
  logic [7:0] r;
  logic [1:0] u;
  int err_total = 0;
  int n_compared = 0;
  int n_events = 0;
  always #4 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    if (output_received_event === 1'b1) n_events <= n_events + 1;
    if (zero_d_buffer === 1'b1) n_zeroes <= n_zeroes + 1;
    if (drop_master === 1'b1) n_drops <= n_drops + 1;
  end
  cyclic_io_if link();
  // ev: 0 out ok, 1 send, 2 exchange, 3 sync, 4 unsync, 5 freeze, 6 clear, 7 lost, 8 await, 9 acked
  cyclic_io_device cyclic_io_device_inst (.core_clk(core_clk), .nrst(nrst), .link(link),
    .out_telegram_ok(ev[0]), .in_send_request(ev[1]), .exchange_telegram(ev[2]),
    .sync_cmd(ev[3]), .unsync_cmd(ev[4]), .freeze_cmd(ev[5]), .clear_cmd(ev[6]),
    .master_lost(ev[7]), .enter_await_params(ev[8]), .params_acked(ev[9]),
    .out_hold_enable(out_hold), .in_hold_enable(in_hold),
    .output_received_event(output_received_event), .zero_d_buffer(zero_d_buffer),
    .out_d_index(out_d_index),
    .in_d_index(in_d_index), .cyclic_exchange_state(cyclic_exchange_state),
    .drop_master(drop_master), .app_alive_counter(app_alive_counter));
  cyclic_io_app cyclic_io_app_inst (.core_clk(core_clk), .nrst(nrst), .link(link),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  cyclic_io_assertions cyclic_io_assertions_inst (.core_clk(core_clk), .nrst(nrst),
    .rd_req(link.rd_req), .rd_addr(link.rd_addr), .rd_ack(link.rd_ack),
    .rd_data(link.rd_data), .rearm_set(link.rearm_set), .alive_reload(link.alive_reload));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // command, then poll busy, then fetch the answer byte
  task automatic cmd(input int bitno, input logic [31:0] extra, output logic [7:0] q);
    logic [31:0] v;
    logic e;
    apb(1'b1, APB_CTRL, (32'h1 << bitno) | extra, v, e);
    // only the watchdog ends a hung poll
    do apb(1'b0, APB_STATUS, 32'h0, v, e);
    while (v[0] !== 1'b0);
    apb(1'b0, APB_RESULT, 32'h0, v, e);
    q = v[7:0];
  endtask
  task automatic pulse(input int i);
    @(posedge core_clk);
    ev[i] <= 1'b1;
    @(posedge core_clk);
    ev <= '0;
    repeat (3) @(posedge core_clk);
  endtask
  // buffer contents live outside this block; software zeroes U and added N bytes
  task automatic t_start_and_advance();
    cmd(CTRL_READ_OUT_POS, 0, r);
    check(r, 8'h1B);
    check({6'h00, out_d_index}, 8'h03);
    cmd(CTRL_READ_IN_POS, 0, r);
    check(r, 8'hD2);
    cmd(CTRL_ADVANCE, 0, r);
    check(r, 8'h0E);
    cmd(CTRL_ADVANCE, 0, r);
    check(r, 8'h0A);
  endtask
  task automatic t_latest_output();
    pulse(0);
    pulse(0);
    check(n_events[7:0], 8'h02);
    cmd(CTRL_READ_OUT_POS, 0, r);
    u = r[3:2];
    cmd(CTRL_ADVANCE, 0, r);
    check(r, {6'h01, u});
  endtask
  task automatic t_output_hold();
    out_hold <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      pulse(0);
      cmd(CTRL_ADVANCE, 0, r);
      check(r & 8'h04, 8'h00);
      pulse(3 + k);
      cmd(CTRL_ADVANCE, 0, r);
      check(r & 8'h04, 8'h04);
    end
    out_hold <= 1'b0;
  endtask
  task automatic t_clears();
    for (int k = 6; k < 9; k++) begin
      pulse(k);
      cmd(CTRL_ADVANCE, 0, r);
      check(r & 8'h0C, 8'h0C);
    end
    check(n_zeroes[7:0], 8'h04);
  endtask
  task automatic t_input();
    cmd(CTRL_READ_IN_POS, 0, r);
    u = r[5:4];
    cmd(CTRL_SUBMIT, 0, r);
    pulse(1);
    check({6'h00, in_d_index}, {6'h00, u});
    in_hold <= 1'b1;
    cmd(CTRL_READ_IN_POS, 0, r);
    u = r[5:4];
    r = {6'h00, in_d_index};
    cmd(CTRL_SUBMIT, 0, r);
    r = {6'h00, in_d_index};
    pulse(1);
    check({6'h00, in_d_index}, r);
    pulse(5);
    check({6'h00, in_d_index}, {6'h00, u});
    in_hold <= 1'b0;
  endtask
  task automatic t_alive();
    logic [31:0] v;
    logic e;
    pulse(9);
    check({7'h00, cyclic_exchange_state}, 8'h01);
    cmd(CTRL_ALIVE_LOAD, 32'h0003_0000, r);
    cmd(CTRL_REARM, 0, r);
    pulse(2);
    check(app_alive_counter[7:0], 8'h03);
    pulse(2);
    check(app_alive_counter[7:0], 8'h02);
    pulse(2);
    pulse(2);
    check({7'h00, cyclic_exchange_state}, 8'h00);
    check(n_drops[7:0], 8'h01);
    apb(1'b0, 12'h010, 32'h0, v, e);
    check({7'h00, e}, 8'h01);
  endtask
  task automatic print_verdict();
    if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge core_clk);
    t_start_and_advance();
    t_latest_output();
    t_output_hold();
    t_clears();
    t_input();
    t_alive();
    print_verdict();
  end
endmodule // cyclic_io_triple_buffer_wdog_tb
